// file: bench/core_regs_sva.sv
// concurrent checks on the core register set and stack unit ports
`timescale 1ns/1ns
module core_regs_sva
    import core_regs_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [2:0] reg_op_i,
    input wire logic [1:0] index_sel_i,
    input wire logic [15:0] operand_i,
    input wire logic [3:0] ins_class_i,
    input wire logic call_i,
    input wire logic irq_entry_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [7:0] push_data_i,
    input wire logic [7:0] index_x_o,
    input wire logic [7:0] stack_ptr_o,
    input wire logic [7:0] program_counter_high_byte_o,
    input wire logic [7:0] core_mode_o,
    input wire logic [15:0] eff_addr_o,
    input wire logic [15:0] stack_addr_o,
    input wire logic stack_we_o,
    input wire logic stack_re_o,
    input wire logic [7:0] stack_wdata_o,
    input wire logic entry_busy_o,
    input wire logic illegal_ins_o,
    input wire logic wait_o,
    input wire logic stop_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    // a single push or pop is only taken when no entry is running or starting;
    // the busy view lags the state by one cycle, so the start cycle is covered here
    logic start_q;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            start_q <= 1'b0;
        end else begin
            start_q <= call_i || irq_entry_i;
        end
    end
    wire logic idle_w = !entry_busy_o && !start_q && !call_i && !irq_entry_i;

    a_push_write: assert property (idle_w && push_i |=> stack_we_o &&
        stack_addr_o[7:0] == stack_ptr_o && stack_wdata_o == $past(push_data_i))
        else $error("push not written at the stack pointer");
    a_push_dec: assert property (idle_w && push_i |=> ##1
        stack_ptr_o == $past(stack_ptr_o) - 8'h01)
        else $error("push did not step the stack pointer down");
    a_pop_read: assert property (idle_w && pop_i && !push_i |=> stack_re_o &&
        stack_addr_o[7:0] == stack_ptr_o + 8'h01)
        else $error("pop not read above the stack pointer");
    a_stack_page: assert property (stack_we_o || stack_re_o |->
        stack_addr_o[15:8] == {7'h00, core_mode_o[STACK_PAGE_BIT]})
        else $error("stack address high byte not the selected page");
    a_eff_addr: assert property (reg_op_i == OP_NONE && index_sel_i == IDX_X |=>
        eff_addr_o == $past(operand_i) + {8'h00, index_x_o})
        else $error("indexed address is not operand plus index");
    a_illegal_ins: assert property (1'b1 |=> illegal_ins_o ==
        ($past(ins_class_i) inside {INS_FAST_SET, INS_SHIFT_LEFT_WORD}))
        else $error("unsupported instruction flag wrong");
    a_wait_stop: assert property (1'b1 |=> wait_o == ($past(ins_class_i) == INS_WAIT) &&
        stop_o == ($past(ins_class_i) == INS_STOP))
        else $error("wait or stop flag wrong");
    a_entry_order: assert property (!entry_busy_o && (call_i || irq_entry_i) |->
        ##2 stack_we_o && stack_wdata_o == program_counter_high_byte_o
        ##1 stack_we_o && stack_addr_o[7:0] == $past(stack_addr_o[7:0]) - 8'h01)
        else $error("entry did not push high then low return byte");
endmodule // core_regs_sva

bind core_regs core_regs_sva i_core_regs_sva (.*);

// file: bench/cpu_core_registers_and_stack_bench.sv
// testbench for the core register set and stack unit
`timescale 1ns/1ns
module cpu_core_registers_and_stack_bench;
    import core_regs_pkg::*;
    logic core_clk_i, rst_i, pc_load_en_i, pc_inc_i, call_i, irq_entry_i, brk_i;
    logic push_i, pop_i, sfr_wr_i, stack_we_o, stack_re_o, entry_busy_o;
    logic illegal_ins_o, wait_o, stop_o;
    logic [2:0] reg_op_i;
    logic [1:0] index_sel_i;
    logic [3:0] ins_class_i;
    logic [7:0] reg_data_i, push_data_i, mem_rdata_i, sfr_wdata_i, acc_o, index_x_o;
    logic [7:0] index_y_o, stack_ptr_o, status_o, program_counter_high_byte_o;
    logic [7:0] program_counter_low_byte_o, core_mode_o, stack_wdata_o, pop_data_o;
    logic [15:0] pc_load_i, operand_i, sfr_addr_i, eff_addr_o, second_operand_addr_o;
    logic [15:0] stack_addr_o;
    logic [23:0] wq [$];
    logic [15:0] ea [3] = '{16'h10f0, 16'h112c, 16'h11e1};
    int n_mismatch = 0;
    int checks = 0;

    core_regs i_core_regs (.*);
    stack_ram_model i_stack_ram_model (.*);

    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        if (stack_we_o === 1'b1)
            wq.push_back({stack_addr_o, stack_wdata_o});
    end

    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cyc(int n = 1);
        repeat (n) @(negedge core_clk_i);
    endtask
    task automatic op(logic [2:0] o, logic [7:0] d);
        reg_op_i = o;
        reg_data_i = d;
        cyc();
        reg_op_i = OP_NONE;
        cyc();
    endtask
    task automatic pushb(logic [7:0] d);
        push_data_i = d;
        push_i = 1'b1;
        cyc();
        push_i = 1'b0;
        cyc(2);
    endtask
    task automatic popb(logic [7:0] e);
        pop_i = 1'b1;
        cyc();
        pop_i = 1'b0;
        cyc(3);
        chk("pop_data", {8'h00, e}, {8'h00, pop_data_o});
    endtask
    task automatic wchk(logic [15:0] a, logic [7:0] d);
        logic [23:0] w;
        w = wq.size() ? wq.pop_front() : 'x;
        chk("stack_addr", a, w[23:8]);
        chk("stack_data", {8'h00, d}, {8'h00, w[7:0]});
    endtask
    task automatic sfrw(logic [15:0] a, logic [7:0] d);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        cyc();
        sfr_wr_i = 1'b0;
        cyc(2);
    endtask

    task automatic t_regs;
        chk("sp", {8'h00, SP_RESET}, {8'h00, stack_ptr_o});
        chk("status", {8'h00, STATUS_RESET}, {8'h00, status_o});
        chk("pc", PC_RESET, {program_counter_high_byte_o, program_counter_low_byte_o});
        op(OP_LOAD_A, 8'ha5);
        op(OP_LOAD_X, 8'h3c);
        op(OP_LOAD_Y, 8'hf1);
        chk("acc", 16'h00a5, {8'h00, acc_o});
        chk("x", 16'h003c, {8'h00, index_x_o});
        chk("y", 16'h00f1, {8'h00, index_y_o});
        pc_load_i = 16'h12ff;
        pc_load_en_i = 1'b1;
        pc_inc_i = 1'b1;
        cyc();
        pc_load_en_i = 1'b0;
        cyc();
        pc_inc_i = 1'b0;
        cyc();
        chk("pc", 16'h1300, {program_counter_high_byte_o, program_counter_low_byte_o});
        $display("test regs done");
    endtask
    task automatic t_index;
        operand_i = 16'h10f0;
        for (int s = 0; s < 3; s++) begin
            index_sel_i = s[1:0];
            cyc(2);
            chk("eff_addr", ea[s], eff_addr_o);
        end
        op(OP_LOAD_STATUS, 8'h34);
        chk("status", 16'h0024, {8'h00, status_o});
        chk("second_op", 16'h003c, second_operand_addr_o);
        op(OP_LOAD_STATUS, 8'h00);
        chk("second_op", 16'h10f0, second_operand_addr_o);
        $display("test index done");
    endtask
    task automatic t_ins;
        for (int i = 0; i < 7; i++) begin
            ins_class_i = i[3:0];
            cyc(2);
            chk("illegal", {15'h0000, i == 1 || i == 2}, {15'h0000, illegal_ins_o});
            chk("wait", {15'h0000, i == 5}, {15'h0000, wait_o});
            chk("stop", {15'h0000, i == 6}, {15'h0000, stop_o});
        end
        ins_class_i = INS_OTHER;
        cyc(2);
        $display("test instructions done");
    endtask
    task automatic t_stack;
        op(OP_LOAD_SP, 8'h01);
        pushb(8'h5a);
        pushb(8'hc3);
        pushb(8'h77);
        wchk(16'h0001, 8'h5a);
        wchk(16'h0000, 8'hc3);
        wchk(16'h00ff, 8'h77);
        chk("sp", 16'h00fe, {8'h00, stack_ptr_o});
        popb(8'h77);
        popb(8'hc3);
        popb(8'h5a);
        sfrw(16'h003a, 8'h04);
        chk("mode", 16'h0000, {8'h00, core_mode_o});
        sfrw(CORE_MODE_ADDR, 8'h04);
        chk("mode", 16'h0004, {8'h00, core_mode_o});
        pushb(8'h99);
        wchk(16'h0101, 8'h99);
        $display("test stack done");
    endtask
    task automatic t_entry;
        irq_entry_i = 1'b1;
        brk_i = 1'b1;
        cyc();
        irq_entry_i = 1'b0;
        brk_i = 1'b0;
        cyc();
        chk("entry_busy", 16'h0001, {15'h0000, entry_busy_o});
        cyc(5);
        wchk(16'h0100, 8'h13);
        wchk(16'h01ff, 8'h00);
        wchk(16'h01fe, 8'h14);
        chk("irq_mask", 16'h0001, {15'h0000, status_o[STATUS_I_BIT]});
        call_i = 1'b1;
        cyc();
        call_i = 1'b0;
        cyc(6);
        wchk(16'h01fd, 8'h13);
        wchk(16'h01fc, 8'h00);
        chk("extra_writes", 16'h0000, 16'(wq.size()));
        $display("test entry done");
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        {rst_i, pc_load_en_i, pc_inc_i, call_i, irq_entry_i, brk_i} = 6'h20;
        {push_i, pop_i, sfr_wr_i, reg_op_i, index_sel_i, ins_class_i} = 12'h000;
        {reg_data_i, push_data_i, sfr_wdata_i} = 24'h000000;
        {pc_load_i, operand_i, sfr_addr_i} = 48'h000000000000;
        cyc(10);
        rst_i = 1'b0;
        cyc(2);
        t_regs();
        t_index();
        t_ins();
        t_stack();
        t_entry();
        close_out();
    end
    initial begin
        #2000000;
        n_mismatch++;
        close_out();
    end
endmodule // cpu_core_registers_and_stack_bench

// file: bench/stack_ram_model.sv
// stack ram model answering the core's stack reads and writes
`timescale 1ns/1ns
module stack_ram_model (
    input wire logic core_clk_i,
    input wire logic [15:0] stack_addr_o,
    input wire logic stack_we_o,
    input wire logic stack_re_o,
    input wire logic [7:0] stack_wdata_o,
    output logic [7:0] mem_rdata_i
);
    logic [7:0] mem_q [512];
    logic [7:0] last_q = 8'h00;
    always @(posedge core_clk_i) begin
        if (stack_we_o)
            mem_q[stack_addr_o[8:0]] <= stack_wdata_o;
        last_q <= mem_rdata_i;
    end
    // outside a read the bus shows the inverse of its value in the cycle before
    assign mem_rdata_i = stack_re_o ? mem_q[stack_addr_o[8:0]] : ~last_q;
endmodule // stack_ram_model

// file: pkg/core_regs_pkg.sv
// constants for the core register set and stack unit
package core_regs_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    localparam logic [15:0] CORE_MODE_ADDR = 16'h003b;
    localparam int STACK_PAGE_BIT = 2;
    localparam logic [7:0] CORE_MODE_RESET = 8'h00;
    localparam logic [7:0] SP_RESET = 8'hff;
    localparam logic [7:0] STATUS_RESET = 8'h04;
    localparam int STATUS_I_BIT = 2;
    localparam int STATUS_B_BIT = 4;
    localparam int STATUS_T_BIT = 5;
    localparam logic [7:0] PAGE_ZERO = 8'h00;
    localparam logic [7:0] PAGE_ONE = 8'h01;
    localparam logic [15:0] PC_RESET = 16'h0000;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_LOAD_A = 3'b001,
        OP_LOAD_X = 3'b010,
        OP_LOAD_Y = 3'b011,
        OP_LOAD_STATUS = 3'b100,
        OP_LOAD_SP = 3'b101
    } reg_op_e;

    typedef enum logic [1:0] {
        IDX_NONE = 2'b00,
        IDX_X = 2'b01,
        IDX_Y = 2'b10
    } index_sel_e;

    typedef enum logic [3:0] {
        INS_OTHER = 4'h0,
        INS_FAST_SET = 4'h1,
        INS_SHIFT_LEFT_WORD = 4'h2,
        INS_MULTIPLY = 4'h3,
        INS_DIVIDE = 4'h4,
        INS_WAIT = 4'h5,
        INS_STOP = 4'h6
    } ins_class_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PUSH_PCH = 2'b01,
        ST_PUSH_PCL = 2'b10,
        ST_PUSH_PS = 2'b11
    } entry_state_e;
endpackage

// file: verilog/core_regs.sv
// core register set with index address and stack address generation
//
// Overview of operation
// - 8-bit accumulator carrying data transfers.
// - two separate 8-bit index registers.
// - indexed effective address is operand plus selected index register.
// - with memory-to-memory flag set, first index register addresses second operand.
// - 8-bit stack pointer used on calls and interrupts.
// - call or interrupt entry saves return address on stack; only interrupt entry also saves status.
// - stack address low byte comes from the stack pointer.
// - page select 0 puts stack in zero page.
// - page select 1 puts stack in page one.
// - page select bit lives in a software-accessible zero-page control register.
// - fast-set and shift-left-word opcodes are not supported.
// - multiply, divide, wait and stop instructions are supported.
// - 16-bit program counter of high and low bytes.
// - interrupt disable flag reads 1 after reset.
// - control register sits at its fixed zero-page address.
`timescale 1ns/1ns
module core_regs
    import core_regs_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [2:0] reg_op_i,
    input wire logic [7:0] reg_data_i,
    input wire logic [15:0] pc_load_i,
    input wire logic pc_load_en_i,
    input wire logic pc_inc_i,
    input wire logic [1:0] index_sel_i,
    input wire logic [15:0] operand_i,
    input wire logic [3:0] ins_class_i,
    input wire logic call_i,
    input wire logic irq_entry_i,
    input wire logic brk_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [7:0] push_data_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic sfr_wr_i,
    input wire logic [15:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] acc_o,
    output logic [7:0] index_x_o,
    output logic [7:0] index_y_o,
    output logic [7:0] stack_ptr_o,
    output logic [7:0] status_o,
    output logic [7:0] program_counter_high_byte_o,
    output logic [7:0] program_counter_low_byte_o,
    output logic [7:0] core_mode_o,
    output logic [15:0] eff_addr_o,
    output logic [15:0] second_operand_addr_o,
    output logic [15:0] stack_addr_o,
    output logic stack_we_o,
    output logic stack_re_o,
    output logic [7:0] stack_wdata_o,
    output logic [7:0] pop_data_o,
    output logic entry_busy_o,
    output logic illegal_ins_o,
    output logic wait_o,
    output logic stop_o
);
    logic [7:0] acc_q;
    logic [7:0] index_x_q;
    logic [7:0] index_y_q;
    logic [7:0] sp_q;
    logic [7:0] sp_d;
    logic [7:0] status_q;
    logic [15:0] pc_q;
    logic [7:0] core_mode_q;
    logic [7:0] stack_page;
    entry_state_e entry_q;
    entry_state_e entry_d;
    logic [7:0] entry_status_q;
    logic [7:0] ins_pop_addr;
    logic stack_we_d;
    logic [7:0] stack_wdata_d;
    logic [7:0] index_val;
    logic [7:0] idx_d;
    reg_op_e op;
    index_sel_e isel;
    ins_class_e icls;

    assign op = reg_op_e'(reg_op_i);
    assign isel = index_sel_e'(index_sel_i);
    assign icls = ins_class_e'(ins_class_i);
    assign stack_page = core_mode_q[STACK_PAGE_BIT] ? PAGE_ONE : PAGE_ZERO;
    assign ins_pop_addr = sp_q + 8'h01;

    // data registers
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            acc_q <= 8'h00;
            index_x_q <= 8'h00;
            index_y_q <= 8'h00;
        end else begin
            if (op == OP_LOAD_A) begin
                acc_q <= reg_data_i;
            end
            if (op == OP_LOAD_X) begin
                index_x_q <= reg_data_i;
            end
            if (op == OP_LOAD_Y) begin
                index_y_q <= reg_data_i;
            end
        end
    end

    // status register; i set on interrupt entry
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            status_q <= STATUS_RESET;
        end else if (irq_entry_i && entry_q == ST_IDLE) begin
            status_q[STATUS_I_BIT] <= 1'b1;
        end else if (op == OP_LOAD_STATUS) begin
            status_q <= reg_data_i & ~(8'h01 << STATUS_B_BIT);
        end
    end

    // program counter
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pc_q <= PC_RESET;
        end else if (pc_load_en_i) begin
            pc_q <= pc_load_i;
        end else if (pc_inc_i) begin
            pc_q <= pc_q + 16'h0001;
        end
    end

    // control register holding the stack page select
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            core_mode_q <= CORE_MODE_RESET;
        end else if (sfr_wr_i && sfr_addr_i == CORE_MODE_ADDR) begin
            core_mode_q <= sfr_wdata_i;
        end
    end

    // entry sequence: pch, pcl, then status on interrupt entry only, pushed in that order
    always_comb begin
        entry_d = entry_q;
        stack_we_d = 1'b0;
        stack_wdata_d = 8'h00;
        sp_d = sp_q;
        unique case (entry_q)
            ST_IDLE: begin
                if (call_i || irq_entry_i) begin
                    entry_d = ST_PUSH_PCH;
                end else if (push_i) begin
                    stack_we_d = 1'b1;
                    stack_wdata_d = push_data_i;
                    sp_d = sp_q - 8'h01;
                end else if (pop_i) begin
                    sp_d = ins_pop_addr;
                end else if (op == OP_LOAD_SP) begin
                    sp_d = reg_data_i;
                end
            end
            ST_PUSH_PCH: begin
                stack_we_d = 1'b1;
                stack_wdata_d = pc_q[15:8];
                sp_d = sp_q - 8'h01;
                entry_d = ST_PUSH_PCL;
            end
            ST_PUSH_PCL: begin
                stack_we_d = 1'b1;
                stack_wdata_d = pc_q[7:0];
                sp_d = sp_q - 8'h01;
                entry_d = entry_status_q[0] ? ST_PUSH_PS : ST_IDLE;
            end
            ST_PUSH_PS: begin
                stack_we_d = 1'b1;
                stack_wdata_d = status_q | (entry_status_q[1] ? 8'h10 : 8'h00);
                sp_d = sp_q - 8'h01;
                entry_d = ST_IDLE;
            end
        endcase
    end

    // bit0: push status (interrupt), bit1: break marker
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            entry_status_q <= 8'h00;
        end else if (entry_q == ST_IDLE) begin
            entry_status_q <= {6'h00, brk_i, irq_entry_i};
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            entry_q <= ST_IDLE;
            sp_q <= SP_RESET;
        end else begin
            entry_q <= entry_d;
            sp_q <= sp_d;
        end
    end

    // stack memory port, registered
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            stack_addr_o <= 16'h0000;
            stack_we_o <= 1'b0;
            stack_re_o <= 1'b0;
            stack_wdata_o <= 8'h00;
            pop_data_o <= 8'h00;
        end else begin
            stack_we_o <= stack_we_d;
            stack_wdata_o <= stack_wdata_d;
            stack_re_o <= pop_i && entry_q == ST_IDLE && !call_i && !irq_entry_i && !push_i;
            if (stack_we_d) begin
                stack_addr_o <= {stack_page, sp_q};
            end else begin
                stack_addr_o <= {stack_page, ins_pop_addr};
            end
            if (stack_re_o) begin
                pop_data_o <= mem_rdata_i;
            end
        end
    end

    // address generation
    always_comb begin
        unique case (isel)
            IDX_X: index_val = index_x_q;
            IDX_Y: index_val = index_y_q;
            default: index_val = 8'h00;
        endcase
        idx_d = index_val;
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            eff_addr_o <= 16'h0000;
            second_operand_addr_o <= 16'h0000;
        end else begin
            eff_addr_o <= operand_i + {8'h00, idx_d};
            if (status_q[STATUS_T_BIT]) begin
                second_operand_addr_o <= {8'h00, index_x_q};
            end else begin
                second_operand_addr_o <= operand_i;
            end
        end
    end

    // instruction class decode
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            illegal_ins_o <= 1'b0;
            wait_o <= 1'b0;
            stop_o <= 1'b0;
        end else begin
            illegal_ins_o <= icls == INS_FAST_SET || icls == INS_SHIFT_LEFT_WORD;
            wait_o <= icls == INS_WAIT;
            stop_o <= icls == INS_STOP;
        end
    end

    // register views
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            acc_o <= 8'h00;
            index_x_o <= 8'h00;
            index_y_o <= 8'h00;
            stack_ptr_o <= SP_RESET;
            status_o <= STATUS_RESET;
            program_counter_high_byte_o <= PC_RESET[15:8];
            program_counter_low_byte_o <= PC_RESET[7:0];
            core_mode_o <= CORE_MODE_RESET;
            entry_busy_o <= 1'b0;
        end else begin
            acc_o <= acc_q;
            index_x_o <= index_x_q;
            index_y_o <= index_y_q;
            stack_ptr_o <= sp_q;
            status_o <= status_q;
            program_counter_high_byte_o <= pc_q[15:8];
            program_counter_low_byte_o <= pc_q[7:0];
            core_mode_o <= core_mode_q;
            entry_busy_o <= entry_q != ST_IDLE;
        end
    end
endmodule // core_regs
